// ===== rtl/sfspi_regs.svh
`ifndef SFSPI_REGS_SVH
`define SFSPI_REGS_SVH

// Bits in one serial byte
`define SFSPI_BYTE_BITS 8
// Least stages of an input synchroniser
`define SFSPI_MIN_STAGES 2
// Pin reset levels {cs_n, sck, io3, io2, io1, io0}: deselected, pull-ups high
`define SFSPI_PIN_RST 6'h2c
// All lanes released
`define SFSPI_OE_N_RST 4'hf
// Falling edges per byte for each lane width
`define SFSPI_FALLS_SINGLE 4'h8
`define SFSPI_FALLS_DUAL 4'h4
`define SFSPI_FALLS_QUAD 4'h2

`endif

// ===== rtl/sfspi_pkg.sv
`default_nettype none
package sfspi_pkg;

  typedef enum logic [1:0] {
    sfspi_w_single = 2'b00,
    sfspi_w_dual = 2'b01,
    sfspi_w_quad = 2'b10
  } sfspi_width_type;

  typedef enum logic {
    sfspi_st_idle = 1'b0,
    sfspi_st_sel = 1'b1
  } sfspi_state_type;

  // Received byte towards the command logic
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } sfspi_rx_type;

  // Byte and lane width offered for the read phase
  typedef struct packed {
    logic enable;
    sfspi_width_type width;
    logic [7:0] data;
  } sfspi_tx_type;

  // Pin drive: value and active-low enable per lane
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe_n;
  } sfspi_lanes_type;

endpackage
`default_nettype wire

// ===== rtl/sfspi_sync.sv
`include "sfspi_regs.svh"
`default_nettype none
module sfspi_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (STAGES < `SFSPI_MIN_STAGES) begin : g_chk
    $error("sfspi_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage_ff [STAGES];
  logic [WIDTH-1:0] nxt_stage [STAGES];

  // First stage feeds only the second
  always_comb begin
    nxt_stage[0] = async_in;
    for (int i = 1; i < STAGES; i++) begin
      nxt_stage[i] = stage_ff[i-1];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_ff[i] <= RST_VAL;
      end
    end else if (ce) begin
      stage_ff <= nxt_stage;
    end
  end

  assign sync_out = stage_ff[STAGES-1];

endmodule
`default_nettype wire

// ===== rtl/sfspi_pin_if.sv
// Function
// - Low select enables, high select means standby
// - Operation starts only at select falling
// - Select rising ends the operation
// - Stay active until internal cycle completes
// - Sample input line on clock rising
// - Change output line on clock falling
// - Input line becomes lane 0 in dual and quad reads
// - Ignore input line while deselected
// - Output line stays a lane in dual
// - Release output line while deselected
// - Lanes 2 and 3 only with quad enable
`include "sfspi_regs.svh"
`default_nettype none
module sfspi_pin_if #(
  parameter int SYNC_STAGES = 2,
  parameter int BYTE_BITS = `SFSPI_BYTE_BITS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic pin_cs_n,
  input wire logic pin_sck,
  input wire logic [3:0] pin_io_in,
  output logic [3:0] pin_io_out,
  output logic [3:0] pin_io_oe_n,
  input wire logic quad_lane_enable_bit,
  input wire logic internal_busy,
  input wire sfspi_pkg::sfspi_tx_type tx_in,
  output logic tx_take,
  output sfspi_pkg::sfspi_rx_type rx_out,
  output logic op_start,
  output logic op_end,
  output logic selected,
  output logic standby,
  output logic wp_n,
  output logic hold_n
);

  if (BYTE_BITS != 8) begin : g_chk
    $error("sfspi_pin_if serves 8-bit bytes only");
  end

  logic [5:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic [3:0] io_s;

  sfspi_sync #(
    .WIDTH(6),
    .STAGES(SYNC_STAGES),
    .RST_VAL(`SFSPI_PIN_RST)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .async_in({pin_cs_n, pin_sck, pin_io_in}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[5];
  assign sck_s = pins_s[4];
  assign io_s = pins_s[3:0];

  function automatic logic [3:0] falls_of(input sfspi_pkg::sfspi_width_type w);
    unique case (w)
      sfspi_pkg::sfspi_w_dual: falls_of = `SFSPI_FALLS_DUAL;
      sfspi_pkg::sfspi_w_quad: falls_of = `SFSPI_FALLS_QUAD;
      default: falls_of = `SFSPI_FALLS_SINGLE;
    endcase
  endfunction

  // Top bits of the byte onto the lanes of the given width
  function automatic sfspi_pkg::sfspi_lanes_type drive_of(input sfspi_pkg::sfspi_width_type w,
                                                          input logic [7:0] b);
    sfspi_pkg::sfspi_lanes_type l;
    l = '0;
    unique case (w)
      sfspi_pkg::sfspi_w_dual: begin
        l.dout = {2'h0, b[7], b[6]};
        l.oe_n = 4'hc;
      end
      sfspi_pkg::sfspi_w_quad: begin
        l.dout = b[7:4];
        l.oe_n = 4'h0;
      end
      default: begin
        l.dout = {2'h0, b[7], 1'b0};
        l.oe_n = 4'hd;
      end
    endcase
    return l;
  endfunction

  function automatic logic [7:0] shift_of(input sfspi_pkg::sfspi_width_type w, input logic [7:0] b);
    unique case (w)
      sfspi_pkg::sfspi_w_dual: shift_of = {b[5:0], 2'h0};
      sfspi_pkg::sfspi_w_quad: shift_of = {b[3:0], 4'h0};
      default: shift_of = {b[6:0], 1'b0};
    endcase
  endfunction

  sfspi_pkg::sfspi_state_type state_ff, nxt_state;
  logic cs_n_d_ff, nxt_cs_n_d;
  logic sck_d_ff, nxt_sck_d;
  logic [7:0] rx_shift_ff, nxt_rx_shift;
  logic [2:0] rx_cnt_ff, nxt_rx_cnt;
  logic rx_first_ff, nxt_rx_first;
  sfspi_pkg::sfspi_rx_type rx_out_ff, nxt_rx_out;
  logic [7:0] tx_shift_ff, nxt_tx_shift;
  logic [3:0] tx_left_ff, nxt_tx_left;
  sfspi_pkg::sfspi_width_type tx_width_ff, nxt_tx_width;
  sfspi_pkg::sfspi_lanes_type lanes_ff, nxt_lanes;
  logic tx_take_ff, nxt_tx_take;
  logic op_start_ff, nxt_op_start;
  logic op_end_ff, nxt_op_end;
  logic standby_ff, nxt_standby;
  logic wp_n_ff, nxt_wp_n;
  logic hold_n_ff, nxt_hold_n;

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  sfspi_pkg::sfspi_width_type eff_width;

  // Edges from synchronised copies, so either idle level works
  // idle level free
  assign sck_rise = sck_s & ~sck_d_ff;
  assign sck_fall = ~sck_s & sck_d_ff;
  assign cs_fall = ~cs_n_s & cs_n_d_ff;
  assign cs_rise = cs_n_s & ~cs_n_d_ff;

  assign eff_width = (tx_in.width == sfspi_pkg::sfspi_w_quad && !quad_lane_enable_bit) ?
                     sfspi_pkg::sfspi_w_single : tx_in.width;

  always_comb begin
    nxt_state = state_ff;
    nxt_cs_n_d = cs_n_s;
    nxt_sck_d = sck_s;
    nxt_rx_shift = rx_shift_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_first = rx_first_ff;
    nxt_rx_out = rx_out_ff;
    nxt_rx_out.valid = 1'b0;
    nxt_tx_shift = tx_shift_ff;
    nxt_tx_left = tx_left_ff;
    nxt_tx_width = tx_width_ff;
    nxt_lanes = lanes_ff;
    nxt_tx_take = 1'b0;
    nxt_op_start = 1'b0;
    nxt_op_end = 1'b0;
    nxt_standby = cs_n_s & ~internal_busy;
    // Dedicated pin functions only when lanes 2 and 3 are not data
    // keep dedicated use
    nxt_wp_n = quad_lane_enable_bit | io_s[2];
    nxt_hold_n = quad_lane_enable_bit | io_s[3];
    unique case (state_ff)
      sfspi_pkg::sfspi_st_idle: begin
        nxt_lanes.oe_n = `SFSPI_OE_N_RST;
        nxt_lanes.dout = 4'h0;
        if (cs_fall) begin
          nxt_state = sfspi_pkg::sfspi_st_sel;
          nxt_op_start = 1'b1;
          nxt_rx_cnt = 3'h0;
          nxt_rx_first = 1'b1;
          nxt_tx_left = 4'h0;
        end
      end
      sfspi_pkg::sfspi_st_sel: begin
        if (cs_rise) begin
          nxt_state = sfspi_pkg::sfspi_st_idle;
          nxt_op_end = 1'b1;
          nxt_lanes.oe_n = `SFSPI_OE_N_RST;
          nxt_lanes.dout = 4'h0;
        end else begin
          if (sck_rise) begin
            nxt_rx_shift = {rx_shift_ff[6:0], io_s[0]};
            nxt_rx_cnt = rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == 3'h7) begin
              nxt_rx_out.valid = 1'b1;
              nxt_rx_out.first = rx_first_ff;
              nxt_rx_out.data = {rx_shift_ff[6:0], io_s[0]};
              nxt_rx_first = 1'b0;
            end
          end
          if (sck_fall) begin
            if (!tx_in.enable) begin
              nxt_lanes.oe_n = `SFSPI_OE_N_RST;
              nxt_tx_left = 4'h0;
            end else if (tx_left_ff == 4'h0) begin
              // Width is taken per byte; a change mid-byte waits
              // lane 1 turns output
              nxt_lanes = drive_of(eff_width, tx_in.data);
              nxt_tx_shift = shift_of(eff_width, tx_in.data);
              nxt_tx_width = eff_width;
              nxt_tx_left = falls_of(eff_width) - 4'h1;
              nxt_tx_take = 1'b1;
            end else begin
              nxt_lanes = drive_of(tx_width_ff, tx_shift_ff);
              nxt_tx_shift = shift_of(tx_width_ff, tx_shift_ff);
              nxt_tx_left = tx_left_ff - 4'h1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= sfspi_pkg::sfspi_st_idle;
      cs_n_d_ff <= 1'b1;
      sck_d_ff <= 1'b0;
      rx_shift_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_first_ff <= 1'b0;
      rx_out_ff <= '0;
      tx_shift_ff <= 8'h00;
      tx_left_ff <= 4'h0;
      tx_width_ff <= sfspi_pkg::sfspi_w_single;
      lanes_ff.dout <= 4'h0;
      lanes_ff.oe_n <= `SFSPI_OE_N_RST;
      tx_take_ff <= 1'b0;
      op_start_ff <= 1'b0;
      op_end_ff <= 1'b0;
      standby_ff <= 1'b1;
      wp_n_ff <= 1'b1;
      hold_n_ff <= 1'b1;
    end else if (ce) begin
      state_ff <= nxt_state;
      cs_n_d_ff <= nxt_cs_n_d;
      sck_d_ff <= nxt_sck_d;
      rx_shift_ff <= nxt_rx_shift;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_first_ff <= nxt_rx_first;
      rx_out_ff <= nxt_rx_out;
      tx_shift_ff <= nxt_tx_shift;
      tx_left_ff <= nxt_tx_left;
      tx_width_ff <= nxt_tx_width;
      lanes_ff <= nxt_lanes;
      tx_take_ff <= nxt_tx_take;
      op_start_ff <= nxt_op_start;
      op_end_ff <= nxt_op_end;
      standby_ff <= nxt_standby;
      wp_n_ff <= nxt_wp_n;
      hold_n_ff <= nxt_hold_n;
    end
  end

  // Release lags the pin by the synchroniser; host must allow it
  assign pin_io_out = lanes_ff.dout;
  assign pin_io_oe_n = lanes_ff.oe_n;
  assign tx_take = tx_take_ff;
  assign rx_out = rx_out_ff;
  assign op_start = op_start_ff;
  assign op_end = op_end_ff;
  assign selected = state_ff;
  assign standby = standby_ff;
  assign wp_n = wp_n_ff;
  assign hold_n = hold_n_ff;

endmodule
`default_nettype wire

// ===== sim/sfspi_pin_if_asserts.sv
`default_nettype none
module sfspi_pin_if_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic quad_lane_enable_bit,
  input wire logic internal_busy,
  input wire logic [3:0] pin_io_oe_n,
  input wire logic tx_take,
  input wire sfspi_pkg::sfspi_rx_type rx_out,
  input wire logic op_start,
  input wire logic op_end,
  input wire logic selected,
  input wire logic standby,
  input wire logic wp_n,
  input wire logic hold_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_release_idle: assert property (!selected |-> pin_io_oe_n == 4'hf)
    else $error("Lanes driven while deselected");
  a_start_marks: assert property ($rose(selected) |-> op_start)
    else $error("Selection without start pulse");
  a_start_pulse: assert property (op_start |=> !op_start && selected)
    else $error("Start pulse malformed");
  a_end_closes: assert property ($fell(selected) |-> op_end)
    else $error("Deselect without end pulse");
  a_busy_standby: assert property (internal_busy |=> !standby)
    else $error("Standby during internal cycle");
  a_rx_selected: assert property (rx_out.valid |-> selected)
    else $error("Byte received while deselected");
  a_quad_gated: assert property (!quad_lane_enable_bit |-> pin_io_oe_n[3:2] == 2'b11)
    else $error("Upper lanes driven without quad enable");
  a_pins_forced: assert property (quad_lane_enable_bit |=> wp_n && hold_n)
    else $error("Protect or pause active in quad mode");
  a_take_drives: assert property (tx_take |-> !pin_io_oe_n[1])
    else $error("Output lane idle at byte load");
  a_lane0_wide: assert property (!pin_io_oe_n[0] |-> !pin_io_oe_n[1])
    else $error("Lane 0 driven alone");
  c_start: cover property (op_start);
  c_first_byte: cover property (rx_out.valid && rx_out.first);
  c_quad: cover property (pin_io_oe_n == 4'h0);
endmodule

bind sfspi_pin_if sfspi_pin_if_asserts i_sfspi_pin_if_asserts (.clock, .nrst, .quad_lane_enable_bit,
  .internal_busy, .pin_io_oe_n, .tx_take, .rx_out, .op_start, .op_end, .selected, .standby, .wp_n, .hold_n);
`default_nettype wire

// ===== sim/sfspi_host_model.sv
`default_nettype none
module sfspi_host_model (
  input wire logic clock,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  output logic cs_n,
  output logic sck,
  output logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cs_n_ff = 1'b1;
  logic sck_ff = 1'b0;
  logic si_ff = 1'b0;
  logic tog_ff = 1'b0;
  logic [1:0] pin_hi_ff = 2'b11;
  // Released output lane wanders so a stale level cannot pass
  always @(posedge clock) tog_ff <= ~tog_ff;
  assign cs_n = cs_n_ff;
  assign sck = sck_ff;
  assign io_in[0] = io_oe_n[0] ? si_ff : io_out[0];
  assign io_in[1] = io_oe_n[1] ? tog_ff : io_out[1];
  // Released upper lanes show the host level, pull-ups by default
  assign io_in[3:2] = {io_oe_n[3] ? pin_hi_ff[1] : io_out[3], io_oe_n[2] ? pin_hi_ff[0] : io_out[2]};
  // Host pulls protect or pause lanes low
  task automatic hold_pins(input logic [1:0] v);
    @(posedge clock);
    pin_hi_ff <= v;
  endtask
  task automatic select(input logic cpol);
    @(posedge clock);
    sck_ff <= cpol;
    @(posedge clock);
    cs_n_ff <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  task automatic deselect(input logic cpol);
    @(posedge clock);
    sck_ff <= cpol;
    repeat (5) @(posedge clock);
    cs_n_ff <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  // Half period of five clocks; lanes read at the rise
  task automatic xfer(input logic [7:0] d, input int w, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      @(posedge clock);
      sck_ff <= 1'b0;
      si_ff <= d[7 - i];
      repeat (5) @(posedge clock);
      sck_ff <= 1'b1;
      q = (w == 4) ? {q[3:0], io_in} : (w == 2) ? {q[5:0], io_in[1:0]} : {q[6:0], io_in[1]};
      repeat (4) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_serial_flash_spi_pin_interface.sv
`default_nettype none
module tb_serial_flash_spi_pin_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic quad_en = 1'b0;
  logic busy = 1'b0;
  sfspi_pkg::sfspi_tx_type tx_in = '0;
  sfspi_pkg::sfspi_rx_type rx_out;
  logic cs_n, sck, tx_take, op_start, op_end, selected, standby, wp_n, hold_n;
  logic [3:0] io_in, io_out, io_oe_n;
  logic [7:0] q;
  logic [7:0] rx_q[$];
  logic first_q[$];
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int starts = 0;
  int ends = 0;
  int takes = 0;
  always #4 clock = ~clock;
  sfspi_pin_if i_sfspi_pin_if (.clock(clock), .nrst(nrst), .ce(1'b1), .pin_cs_n(cs_n), .pin_sck(sck),
    .pin_io_in(io_in), .pin_io_out(io_out), .pin_io_oe_n(io_oe_n), .quad_lane_enable_bit(quad_en),
    .internal_busy(busy), .tx_in(tx_in), .tx_take(tx_take), .rx_out(rx_out), .op_start(op_start),
    .op_end(op_end), .selected(selected), .standby(standby), .wp_n(wp_n), .hold_n(hold_n));
  sfspi_host_model i_sfspi_host_model (.clock(clock), .io_out(io_out), .io_oe_n(io_oe_n), .cs_n(cs_n),
    .sck(sck), .io_in(io_in));
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rx_out.valid === 1'b1) begin
      rx_q.push_back(rx_out.data);
      first_q.push_back(rx_out.first);
    end
    if (op_start === 1'b1) starts <= starts + 1;
    if (op_end === 1'b1) ends <= ends + 1;
    if (tx_take === 1'b1) takes <= takes + 1;
    if (cycles == 6000) begin
      errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      final_report();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic t_write();
    int e0;
    e0 = ends;
    i_sfspi_host_model.select(1'b0);
    check(8'(selected), 8'h01);
    check(8'(standby), 8'h00);
    i_sfspi_host_model.xfer(8'ha5, 1, q);
    i_sfspi_host_model.xfer(8'h3c, 1, q);
    repeat (6) @(posedge clock);
    check(8'(rx_q.size()), 8'h02);
    check(rx_q[0], 8'ha5);
    check({7'h00, first_q[0]}, 8'h01);
    check(rx_q[1], 8'h3c);
    check({7'h00, first_q[1]}, 8'h00);
    i_sfspi_host_model.deselect(1'b0);
    check(8'(selected), 8'h00);
    check(8'(ends - e0), 8'h01);
    $display("test write done");
  endtask
  task automatic t_read(input sfspi_pkg::sfspi_width_type wd, input int w, input logic qv, input logic [7:0] b,
                        input logic cpol);
    int t0;
    t0 = takes;
    @(posedge clock);
    quad_en <= qv;
    tx_in <= '{enable: cpol, width: wd, data: b};
    i_sfspi_host_model.select(cpol);
    // Mode 0 needs a command byte first so a fall precedes data
    if (!cpol) begin
      i_sfspi_host_model.xfer(8'h5a, 1, q);
      tx_in.enable <= 1'b1;
    end
    i_sfspi_host_model.xfer(8'h00, w, q);
    check(q, b);
    i_sfspi_host_model.xfer(8'h00, w, q);
    check(q, b);
    check(8'(takes - t0), 8'h02);
    i_sfspi_host_model.deselect(cpol);
    check({4'h0, io_oe_n}, 8'h0f);
    tx_in <= '0;
    quad_en <= 1'b0;
    $display("test read %0d done", w);
  endtask
  task automatic t_idle();
    int n0;
    int s0;
    n0 = rx_q.size();
    s0 = starts;
    i_sfspi_host_model.xfer(8'hff, 1, q);
    repeat (6) @(posedge clock);
    check(8'(rx_q.size() - n0), 8'h00);
    check(8'(starts - s0), 8'h00);
    check({4'h0, io_oe_n}, 8'h0f);
    $display("test idle done");
  endtask
  task automatic t_busy();
    @(posedge clock);
    busy <= 1'b1;
    repeat (3) @(posedge clock);
    check(8'(standby), 8'h00);
    busy <= 1'b0;
    repeat (3) @(posedge clock);
    check(8'(standby), 8'h01);
    $display("test busy done");
  endtask
  task automatic t_protect();
    i_sfspi_host_model.hold_pins(2'b10);
    repeat (5) @(posedge clock);
    check({6'h00, hold_n, wp_n}, 8'h02);
    quad_en <= 1'b1;
    repeat (3) @(posedge clock);
    check({6'h00, hold_n, wp_n}, 8'h03);
    quad_en <= 1'b0;
    i_sfspi_host_model.hold_pins(2'b11);
    repeat (5) @(posedge clock);
    check({6'h00, hold_n, wp_n}, 8'h03);
    $display("test protect done");
  endtask
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    t_write();
    t_read(sfspi_pkg::sfspi_w_single, 1, 1'b0, 8'h96, 1'b1);
    t_read(sfspi_pkg::sfspi_w_dual, 2, 1'b0, 8'h5b, 1'b1);
    t_read(sfspi_pkg::sfspi_w_quad, 4, 1'b1, 8'hc3, 1'b1);
    t_read(sfspi_pkg::sfspi_w_quad, 1, 1'b0, 8'h69, 1'b1);
    t_read(sfspi_pkg::sfspi_w_dual, 2, 1'b0, 8'h4e, 1'b0);
    t_idle();
    t_busy();
    t_protect();
    final_report();
  end
endmodule
`default_nettype wire
